// ### verilog/amw_regs.svh
// Timing counts, field widths and reset values for the async-memory wait time-out block.
// Assumes a 250 MHz interface clock; included by the package and the design modules.
`ifndef AMW_REGS_SVH
`define AMW_REGS_SVH

// ********************************************************************
// Widths
// ********************************************************************
`define AMW_CS_NUM        4
`define AMW_CS_W          2
`define AMW_ADDR_W        23
`define AMW_DATA_W        32
`define AMW_WCNT_W        8
`define AMW_PHASE_W       4

// ********************************************************************
// Access phase lengths in interface clock cycles
// ********************************************************************
`define AMW_SETUP_CYC     4'h2
`define AMW_STROBE_CYC    4'h4
`define AMW_HOLD_CYC      4'h1

// ********************************************************************
// Reset and constant values
// ********************************************************************
`define AMW_ZERO_DATA     32'h0000_0000
`define AMW_ZERO_ADDR     23'h00_0000
`define AMW_ZERO_WCNT     8'h00
`define AMW_FULL_WCNT     8'hff
`define AMW_ZERO_PHASE    4'h0
`define AMW_ONE_PHASE     4'h1
`define AMW_CS_IDLE       4'hf

`endif

// ### verilog/amw_pkg.sv
// Types shared by the async-memory wait time-out block.
// Assumes amw_regs.svh is on the include path.
`include "amw_regs.svh"

package amw_pkg;

  // ********************************************************************
  // Request kinds from the on-chip bus master
  // ********************************************************************
  typedef enum logic [1:0] {
    AMW_KIND_ASYNC = 2'h0,
    AMW_KIND_CTRL  = 2'h1,
    AMW_KIND_NONE  = 2'h2
  } amw_kind_t;

  // ********************************************************************
  // Access sequencer states
  // ********************************************************************
  typedef enum logic [2:0] {
    AMW_ST_IDLE,
    AMW_ST_SETUP,
    AMW_ST_STROBE,
    AMW_ST_HOLD,
    AMW_ST_RESP
  } amw_state_t;

endpackage

// ### verilog/amw_wait_counter.sv
// Counter of cycles spent with the memory wait input active during one access.
// Assumes clear and enable come from logic on the same clock.
`timescale 1ns/1ps
`include "amw_regs.svh"

module amw_wait_counter
  import amw_pkg::*;
(
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     clear_in,
  input  wire logic                     count_en_in,
  input  wire logic [`AMW_WCNT_W-1:0]   limit_in,
  output logic      [`AMW_WCNT_W-1:0]   count_out,
  output logic                          over_out
);

  logic [`AMW_WCNT_W-1:0] count_reg;
  logic [`AMW_WCNT_W-1:0] count_next;

  // ********************************************************************
  // Next count: restart per access, saturate at the top
  // ********************************************************************
  always_comb begin
    count_next = count_reg;
    if (clear_in) begin
      count_next = `AMW_ZERO_WCNT;   // see RULE_08
    end else if (count_en_in && (count_reg != `AMW_FULL_WCNT)) begin
      count_next = count_reg + 8'h01;   // see RULE_08
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      count_reg <= `AMW_ZERO_WCNT;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_out = count_reg;
  assign over_out  = (count_reg > limit_in);   // see RULE_08

endmodule // amw_wait_counter

// ### verilog/amw_timeout_ctrl.sv
// Asynchronous memory read port with extended-wait time-out and a held error flag.
// Assumes a single 250 MHz clock; wait and data pins are asynchronous and are synchronised here;
// control register data comes from on-chip logic on the same clock; an SDRAM controller pulses
// sdram_done_in when it completes an access.
//
// Functional notes
// (RULE_01) With extended wait on, a read whose wait outlasts the maximum flags a time-out.
// (RULE_02) A read that times out returns an all-zero data word.
// (RULE_03) Control register reads after a time-out return true data but still flag the error.
// (RULE_04) The error holds until a clean async access or any SDRAM access completes.
// (RULE_05) Master may clear it by a dummy read to a chip select without extended wait.
// (RULE_06) Master may disable extended wait, then dummy read the same chip select.
// (RULE_07) Master may clear it by one dummy SDRAM read.
// (RULE_08) Wait-active cycles are counted, restarted each access, compared to the maximum.
`timescale 1ns/1ps
`include "amw_regs.svh"

module amw_timeout_ctrl
  import amw_pkg::*;
(
  input  wire logic                                core_clk_in,
  input  wire logic                                rst_n_in,
  // Bus master request
  input  wire logic                                req_valid_in,
  input  wire logic [1:0]                          req_kind_in,
  input  wire logic [`AMW_CS_W-1:0]                req_cs_in,
  input  wire logic [`AMW_ADDR_W-1:0]              req_addr_in,
  output logic                                     req_ready_out,
  // Answer to the bus master
  output logic                                     rsp_valid_out,
  output logic [`AMW_DATA_W-1:0]                   rsp_data_out,
  output logic                                     rsp_err_out,
  // Configuration per chip select
  input  wire logic [`AMW_CS_NUM-1:0]              ext_wait_en_in,
  input  wire logic [`AMW_CS_NUM*`AMW_WCNT_W-1:0]  max_wait_in,
  // Control register space and SDRAM side
  input  wire logic [`AMW_DATA_W-1:0]              ctrl_rdata_in,
  input  wire logic                                sdram_done_in,
  // Status
  output logic                                     timeout_err_out,
  output logic [`AMW_WCNT_W-1:0]                   wait_count_out,
  // Memory pins
  output logic [`AMW_CS_NUM-1:0]                   mem_cs_n_out,
  output logic                                     mem_oe_n_out,
  output logic [`AMW_ADDR_W-1:0]                   mem_addr_out,
  input  wire logic                                mem_wait_in,
  input  wire logic [`AMW_DATA_W-1:0]              mem_data_in
);

  // ********************************************************************
  // Decoding helpers
  // ********************************************************************
  function automatic logic [`AMW_WCNT_W-1:0] max_of(
    input logic [`AMW_CS_NUM*`AMW_WCNT_W-1:0] vec,
    input logic [`AMW_CS_W-1:0]               cs
  );
    max_of = vec[cs*`AMW_WCNT_W +: `AMW_WCNT_W];
  endfunction

  function automatic logic cs_hit(
    input logic [`AMW_CS_W-1:0] cs,
    input int                   idx
  );
    cs_hit = (cs == idx[`AMW_CS_W-1:0]);
  endfunction

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic                    wait_meta_reg;
  logic                    wait_sync_reg;
  logic [`AMW_DATA_W-1:0]  data_meta_reg;
  logic [`AMW_DATA_W-1:0]  data_sync_reg;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wait_meta_reg <= 1'b0;
      wait_sync_reg <= 1'b0;
      data_meta_reg <= `AMW_ZERO_DATA;
      data_sync_reg <= `AMW_ZERO_DATA;
    end else begin
      wait_meta_reg <= mem_wait_in;
      wait_sync_reg <= wait_meta_reg;
      data_meta_reg <= mem_data_in;
      data_sync_reg <= data_meta_reg;
    end
  end

  // ********************************************************************
  // Sequencer state
  // ********************************************************************
  amw_state_t                state_reg;
  amw_state_t                state_next;
  logic [`AMW_PHASE_W-1:0]   phase_reg;
  logic [`AMW_PHASE_W-1:0]   phase_next;
  logic [`AMW_CS_W-1:0]      cs_reg;
  logic [`AMW_CS_W-1:0]      cs_next;
  logic [`AMW_ADDR_W-1:0]    addr_reg;
  logic [`AMW_ADDR_W-1:0]    addr_next;
  logic                      ext_reg;
  logic                      ext_next;
  logic                      is_ctrl_reg;
  logic                      is_ctrl_next;
  logic                      tout_reg;
  logic                      tout_next;
  logic [`AMW_DATA_W-1:0]    data_reg;
  logic [`AMW_DATA_W-1:0]    data_next;
  logic                      err_hold_reg;
  logic                      err_hold_next;
  logic                      rsp_err_reg;
  logic                      rsp_err_next;
  logic                      rsp_valid_reg;
  logic                      rsp_valid_next;
  logic [`AMW_CS_NUM-1:0]    cs_n_reg;
  logic [`AMW_CS_NUM-1:0]    cs_n_next;
  logic                      oe_n_reg;
  logic                      oe_n_next;

  logic                      wcnt_clear;
  logic                      wcnt_en;
  logic                      wcnt_over;
  logic [`AMW_WCNT_W-1:0]    wcnt_value;
  logic                      async_clean_done;
  logic                      async_tout_done;

  amw_wait_counter u_wait_counter (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .clear_in    (wcnt_clear),
    .count_en_in (wcnt_en),
    .limit_in    (max_of(max_wait_in, cs_reg)),
    .count_out   (wcnt_value),
    .over_out    (wcnt_over)
  );

  assign req_ready_out = (state_reg == AMW_ST_IDLE);

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  always_comb begin
    state_next       = state_reg;
    phase_next       = phase_reg;
    cs_next          = cs_reg;
    addr_next        = addr_reg;
    ext_next         = ext_reg;
    is_ctrl_next     = is_ctrl_reg;
    tout_next        = tout_reg;
    data_next        = data_reg;
    rsp_valid_next   = 1'b0;
    rsp_err_next     = rsp_err_reg;
    cs_n_next        = cs_n_reg;
    oe_n_next        = oe_n_reg;
    wcnt_clear       = 1'b0;
    wcnt_en          = 1'b0;
    async_clean_done = 1'b0;
    async_tout_done  = 1'b0;
    case (state_reg)
      AMW_ST_IDLE: begin
        if (req_valid_in && (req_kind_in == AMW_KIND_ASYNC)) begin
          cs_next      = req_cs_in;
          addr_next    = req_addr_in;
          ext_next     = ext_wait_en_in[req_cs_in];
          is_ctrl_next = 1'b0;
          tout_next    = 1'b0;
          phase_next   = `AMW_SETUP_CYC;
          wcnt_clear   = 1'b1;   // see RULE_08
          state_next   = AMW_ST_SETUP;
          for (int i = 0; i < `AMW_CS_NUM; i++) begin
            cs_n_next[i] = !cs_hit(req_cs_in, i);
          end
        end else if (req_valid_in && (req_kind_in == AMW_KIND_CTRL)) begin
          is_ctrl_next = 1'b1;
          data_next    = ctrl_rdata_in;   // see RULE_03
          state_next   = AMW_ST_RESP;
        end
      end
      AMW_ST_SETUP: begin
        phase_next = phase_reg - `AMW_ONE_PHASE;
        if (phase_reg == `AMW_ONE_PHASE) begin
          phase_next = `AMW_STROBE_CYC;
          oe_n_next  = 1'b0;
          state_next = AMW_ST_STROBE;
        end
      end
      AMW_ST_STROBE: begin
        if (phase_reg != `AMW_ZERO_PHASE) begin
          phase_next = phase_reg - `AMW_ONE_PHASE;
        end
        if (ext_reg && wait_sync_reg && wcnt_over) begin
          tout_next  = 1'b1;   // see RULE_01
          data_next  = `AMW_ZERO_DATA;   // see RULE_02
          oe_n_next  = 1'b1;
          phase_next = `AMW_HOLD_CYC;
          state_next = AMW_ST_HOLD;
        end else if (ext_reg && wait_sync_reg) begin
          wcnt_en    = 1'b1;   // see RULE_08
        end else if (phase_reg <= `AMW_ONE_PHASE) begin
          data_next  = data_sync_reg;
          oe_n_next  = 1'b1;
          phase_next = `AMW_HOLD_CYC;
          state_next = AMW_ST_HOLD;
        end
      end
      AMW_ST_HOLD: begin
        phase_next = phase_reg - `AMW_ONE_PHASE;
        if (phase_reg == `AMW_ONE_PHASE) begin
          cs_n_next  = `AMW_CS_IDLE;
          state_next = AMW_ST_RESP;
        end
      end
      AMW_ST_RESP: begin
        rsp_valid_next = 1'b1;
        if (is_ctrl_reg) begin
          rsp_err_next = err_hold_reg;   // see RULE_03
        end else begin
          rsp_err_next     = tout_reg;
          async_tout_done  = tout_reg;
          async_clean_done = !tout_reg;
        end
        state_next = AMW_ST_IDLE;
      end
      default: begin
        state_next = AMW_ST_IDLE;
        cs_n_next  = `AMW_CS_IDLE;
        oe_n_next  = 1'b1;
      end
    endcase
    // Recovery reads (clean async or any SDRAM) release the held error; a new time-out wins
    err_hold_next = err_hold_reg;
    if (async_clean_done || sdram_done_in) begin
      err_hold_next = 1'b0;   // see RULE_04, RULE_05, RULE_06, RULE_07
    end
    if (async_tout_done) begin
      err_hold_next = 1'b1;   // see RULE_04
    end
  end

  // ********************************************************************
  // State registers
  // ********************************************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_reg     <= AMW_ST_IDLE;
      phase_reg     <= `AMW_ZERO_PHASE;
      cs_reg        <= '0;
      addr_reg      <= `AMW_ZERO_ADDR;
      ext_reg       <= 1'b0;
      is_ctrl_reg   <= 1'b0;
      tout_reg      <= 1'b0;
      data_reg      <= `AMW_ZERO_DATA;
      err_hold_reg  <= 1'b0;
      rsp_err_reg   <= 1'b0;
      rsp_valid_reg <= 1'b0;
      cs_n_reg      <= `AMW_CS_IDLE;
      oe_n_reg      <= 1'b1;
    end else begin
      state_reg     <= state_next;
      phase_reg     <= phase_next;
      cs_reg        <= cs_next;
      addr_reg      <= addr_next;
      ext_reg       <= ext_next;
      is_ctrl_reg   <= is_ctrl_next;
      tout_reg      <= tout_next;
      data_reg      <= data_next;
      err_hold_reg  <= err_hold_next;
      rsp_err_reg   <= rsp_err_next;
      rsp_valid_reg <= rsp_valid_next;
      cs_n_reg      <= cs_n_next;
      oe_n_reg      <= oe_n_next;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign rsp_valid_out   = rsp_valid_reg;
  assign rsp_data_out    = data_reg;
  assign rsp_err_out     = rsp_err_reg;
  assign timeout_err_out = err_hold_reg;
  assign wait_count_out  = wcnt_value;
  assign mem_cs_n_out    = cs_n_reg;
  assign mem_oe_n_out    = oe_n_reg;
  assign mem_addr_out    = addr_reg;

endmodule // amw_timeout_ctrl

// ### verif/amw_timeout_ctrl_props.sv
// Assertion checker for the async-memory wait time-out controller.
// Assumes it is bound to amw_timeout_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`include "amw_regs.svh"

module amw_timeout_ctrl_props
  import amw_pkg::*;
(
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    req_valid_in,
  input  wire logic [1:0]              req_kind_in,
  input  wire logic                    req_ready_out,
  input  wire logic                    rsp_valid_out,
  input  wire logic [`AMW_DATA_W-1:0]  rsp_data_out,
  input  wire logic                    rsp_err_out,
  input  wire logic                    sdram_done_in,
  input  wire logic                    timeout_err_out,
  input  wire logic [`AMW_CS_NUM-1:0]  mem_cs_n_out,
  input  wire logic                    mem_oe_n_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ****************************************************************
  // Marks an answer that belongs to an async memory access
  // ****************************************************************
  logic async_seen_reg;
  logic async_seen_next;
  logic take;
  assign take = req_valid_in && req_ready_out;
  always_comb begin
    async_seen_next = async_seen_reg;
    if (mem_cs_n_out != `AMW_CS_IDLE) begin
      async_seen_next = 1'b1;
    end else if (rsp_valid_out) begin
      async_seen_next = 1'b0;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      async_seen_reg <= 1'b0;
    end else begin
      async_seen_reg <= async_seen_next;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  chk_reset_idle: assert property (disable iff (1'b0) !rst_n_in |=>
    mem_cs_n_out == `AMW_CS_IDLE && !rsp_valid_out && !timeout_err_out) else $error("state not idle after reset");
  chk_rsp_single: assert property (rsp_valid_out |=> !rsp_valid_out) else $error("answer pulse too long");
  chk_err_set: assert property (rsp_valid_out && rsp_err_out |=> timeout_err_out)
    else $error("error answer did not set held error");
  chk_err_rise: assert property ($rose(timeout_err_out) |-> rsp_valid_out && rsp_err_out)
    else $error("held error rose without error answer");
  chk_err_hold: assert property ($fell(timeout_err_out) |->
    $past(sdram_done_in) || (rsp_valid_out && !rsp_err_out && async_seen_reg)) else $error("held error cleared early");
  chk_zero_data: assert property (rsp_valid_out && rsp_err_out && async_seen_reg |->
    rsp_data_out == `AMW_ZERO_DATA) else $error("timed-out read data not zero");
  chk_ctrl_err: assert property (rsp_valid_out && !async_seen_reg |-> rsp_err_out == timeout_err_out)
    else $error("control read error flag wrong");
  chk_ctrl_lat: assert property (take && req_kind_in == 2'h1 |-> ##2 rsp_valid_out)
    else $error("control read latency wrong");
  chk_async_min: assert property (take && req_kind_in == 2'h0 |=> !rsp_valid_out [*8])
    else $error("async read answered too early");
  chk_cs_onehot: assert property (mem_cs_n_out != `AMW_CS_IDLE |-> $onehot(~mem_cs_n_out) && !req_ready_out)
    else $error("chip select not one-hot or ready high");
  chk_oe_in_cs: assert property (!mem_oe_n_out |-> mem_cs_n_out != `AMW_CS_IDLE)
    else $error("output enable outside chip select");

  cov_timeout: cover property (rsp_valid_out && rsp_err_out && async_seen_reg);
  cov_ctrl_err: cover property (rsp_valid_out && rsp_err_out && !async_seen_reg);
  cov_sdram_clr: cover property (sdram_done_in && timeout_err_out ##1 !timeout_err_out);
endmodule // amw_timeout_ctrl_props

bind amw_timeout_ctrl amw_timeout_ctrl_props chk_u (.core_clk_in, .rst_n_in, .req_valid_in, .req_kind_in,
  .req_ready_out, .rsp_valid_out, .rsp_data_out, .rsp_err_out, .sdram_done_in, .timeout_err_out,
  .mem_cs_n_out, .mem_oe_n_out);

// ### verif/amw_mem_model.sv
// Behavioural async memory that drives wait and read data.
// Assumes the controller's chip selects and output enable; stall_in sets wait length (8'hff = never).
`timescale 1ns/1ps
`include "amw_regs.svh"

module amw_mem_model
  import amw_pkg::*;
(
  input  wire logic                    core_clk_in,
  input  wire logic [`AMW_CS_NUM-1:0]  mem_cs_n_in,
  input  wire logic                    mem_oe_n_in,
  input  wire logic [`AMW_ADDR_W-1:0]  mem_addr_in,
  input  wire logic [7:0]              stall_in,
  output logic                         mem_wait_out,
  output logic [`AMW_DATA_W-1:0]       mem_data_out
);
  logic [7:0]             cnt_reg = 8'h00;
  logic [`AMW_DATA_W-1:0] idle_reg = 32'h0000_0000;
  logic                   drive;
  assign drive = mem_cs_n_in != `AMW_CS_IDLE && !mem_oe_n_in;
  // Wait is pulled inactive while not selected
  assign mem_wait_out = drive && stall_in != 8'h00 && (stall_in == 8'hff || cnt_reg < stall_in);
  // Released bus shows a pattern that flips every cycle
  assign mem_data_out = drive ? {mem_addr_in[8:0], mem_addr_in} : idle_reg;
  always @(posedge core_clk_in) begin
    cnt_reg <= drive ? cnt_reg + 8'h01 : 8'h00;
    idle_reg <= ~mem_data_out;
  end
endmodule // amw_mem_model

// ### verif/test_async_mem_wait_timeout.sv
// Self-checking bench for the async-memory wait time-out controller.
// Assumes the memory model in amw_mem_model.sv and the checker bound in the props file.
`timescale 1ns/1ps
`include "amw_regs.svh"

module test_async_mem_wait_timeout;
  logic core_clk_in, rst_n_in, req_valid_in, req_ready_out, rsp_valid_out, rsp_err_out;
  logic sdram_done_in, timeout_err_out, mem_oe_n_out, mem_wait_in, err_model;
  logic [1:0]  req_kind_in, req_cs_in;
  logic [3:0]  ext_wait_en_in, mem_cs_n_out;
  logic [7:0]  wait_count_out, mem_stall, mx;
  logic [22:0] req_addr_in, mem_addr_out;
  logic [31:0] max_wait_in, ctrl_rdata_in, rsp_data_out, mem_data_in, r;
  int          seed, errors, cmp_count, cycles;

  amw_timeout_ctrl dut_u (.core_clk_in, .rst_n_in, .req_valid_in, .req_kind_in, .req_cs_in, .req_addr_in,
    .req_ready_out, .rsp_valid_out, .rsp_data_out, .rsp_err_out, .ext_wait_en_in, .max_wait_in,
    .ctrl_rdata_in, .sdram_done_in, .timeout_err_out, .wait_count_out, .mem_cs_n_out, .mem_oe_n_out,
    .mem_addr_out, .mem_wait_in, .mem_data_in);
  amw_mem_model mem_u (.core_clk_in, .mem_cs_n_in(mem_cs_n_out), .mem_oe_n_in(mem_oe_n_out),
    .mem_addr_in(mem_addr_out), .stall_in(mem_stall), .mem_wait_out(mem_wait_in), .mem_data_out(mem_data_in));

  // ****************************************************************
  // Clock, watchdog and closing
  // ****************************************************************
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    rst_n_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    err_model = 1'b0;
    @(negedge core_clk_in);
    check({26'h0, req_ready_out, mem_cs_n_out, timeout_err_out}, {26'h0, 1'b1, 4'hf, 1'b0});
    @(posedge core_clk_in);
  endtask
  task automatic cfg(input logic [3:0] ext, input logic [7:0] st);
    mx = (8'($random(seed)) & 8'h0f) + 8'h01;
    max_wait_in <= {4{mx}};
    ext_wait_en_in <= ext;
    mem_stall <= st;
    @(posedge core_clk_in);
  endtask
  task automatic sdram_hit();
    sdram_done_in <= 1'b1;
    @(posedge core_clk_in);
    sdram_done_in <= 1'b0;
    err_model = 1'b0;
    @(negedge core_clk_in);
    check({31'h0, timeout_err_out}, 32'h0);
    @(posedge core_clk_in);
  endtask
  task automatic acc(input logic [1:0] k, input logic [1:0] c);
    logic [31:0] ed;
    logic [22:0] a;
    logic        to;
    a = 23'($random(seed));
    // A stall of N counted wait cycles outlasts the maximum once N exceeds max plus one
    to = k == 2'h0 && ext_wait_en_in[c] && (mem_stall == 8'hff || mem_stall > mx + 8'h01);
    req_valid_in <= 1'b1;
    req_kind_in <= k;
    req_cs_in <= c;
    req_addr_in <= a;
    ctrl_rdata_in <= $random(seed);
    @(negedge core_clk_in);
    while (req_ready_out !== 1'b1) @(negedge core_clk_in);
    @(posedge core_clk_in);
    req_valid_in <= 1'b0;
    while (rsp_valid_out !== 1'b1) @(negedge core_clk_in);
    ed = (k == 2'h1) ? ctrl_rdata_in : (to ? 32'h0 : {a[8:0], a});
    if (k == 2'h0) err_model = to;
    check(rsp_data_out, ed);
    check({31'h0, rsp_err_out}, {31'h0, err_model});
    @(negedge core_clk_in);
    check({31'h0, timeout_err_out}, {31'h0, err_model});
    if (k == 2'h0 && (to || mem_stall == 8'h00)) begin
      check({31'h0, to ? wait_count_out > mx : wait_count_out == 8'h00}, 32'h1);
    end
    @(posedge core_clk_in);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 81;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    req_valid_in <= 1'b0;
    req_kind_in <= 2'h0;
    req_cs_in <= 2'h0;
    req_addr_in <= 23'h0;
    ext_wait_en_in <= 4'h0;
    max_wait_in <= 32'h0505_0505;
    ctrl_rdata_in <= 32'h0;
    sdram_done_in <= 1'b0;
    mem_stall <= 8'h00;
    do_reset();
    cfg(4'hf, 8'hff);
    acc(2'h0, 2'h0);
    acc(2'h1, 2'h0);
    acc(2'h1, 2'h1);
    sdram_hit();
    acc(2'h0, 2'h1);
    cfg(4'hb, 8'hff);
    acc(2'h0, 2'h2);
    cfg(4'hf, 8'hff);
    acc(2'h0, 2'h3);
    cfg(4'h7, 8'hff);
    acc(2'h0, 2'h3);
    req_valid_in <= 1'b1;
    for (int k = 2; k < 4; k++) begin
      req_kind_in <= 2'(k);
      repeat (4) begin
        @(negedge core_clk_in);
        check({27'h0, mem_cs_n_out, rsp_valid_out}, {27'h0, 4'hf, 1'b0});
      end
      @(posedge core_clk_in);
    end
    req_valid_in <= 1'b0;
    @(posedge core_clk_in);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      cfg(r[3:0], r[5:4] == 2'h0 ? 8'h00 : (r[5:4] == 2'h1 ? 8'h03 : 8'hff));
      if (r[6]) sdram_hit();
      acc({1'b0, r[7]}, r[9:8]);
    end
    cfg(4'hf, 8'hff);
    acc(2'h0, 2'h2);
    do_reset();
    acc(2'h1, 2'h0);
    end_of_test();
  end
endmodule // test_async_mem_wait_timeout
